/* File: rtl/tsw_system_words.sv */
/*
 * System words of a battery-assisted tag: lock words, sensor words with
 * monitoring counters, seconds counter, scratch words, pin and assist words.
 * Assumes the protocol engine hands over decoded word accesses and command
 * pulses on mclk, and that analog sampling is done outside.
 */
`timescale 1ns/1ns
`default_nettype none

module tsw_system_words #(
    parameter int unsigned SEC_CYCLES = tsw_pkg::SEC_CYCLES
) (
    input  wire logic                   mclk,
    input  wire logic                   reset_n,
    input  wire tsw_pkg::tsw_word_req_t rf_req,
    output logic                        rf_done,
    output logic                        rf_refused,
    output logic [15:0]                 rf_rdata,
    input  wire logic                   spi_wr,
    input  wire logic [2:0]             spi_idx,
    input  wire logic [15:0]            spi_wdata,
    output logic [15:0]                 spi_rdata,
    input  wire logic                   permalock_valid,
    input  wire logic [5:0]             permalock_blk,
    input  wire logic                   sensor_fetch_command,
    output logic                        ondemand_go,
    output logic                        ondemand_tamper,
    output logic                        ondemand_low_batt,
    output logic                        ondemand_temp,
    input  wire tsw_pkg::tsw_ondemand_t ondemand_result,
    input  wire tsw_pkg::tsw_meas_t     mon_sample,
    input  wire logic [8:0]             under_threshold,
    input  wire logic [8:0]             over_threshold,
    input  wire logic [4:0]             alarm_samples,
    input  wire logic                   interval_nonzero,
    input  wire logic                   stamp_required,
    input  wire logic                   tamper_enable,
    input  wire logic                   aux_event,
    input  wire logic                   alarm_reset_command,
    input  wire logic                   time_broadcast_command,
    input  wire logic [31:0]            time_broadcast_value,
    input  wire logic                   sensor_page_written,
    input  wire logic                   sleep_ready_boot,
    input  wire logic                   scr_page0_is_id,
    input  wire logic                   scr_page1_is_id,
    input  wire logic                   spi_slave_mode,
    input  wire logic                   field_ok,
    input  wire logic                   assist_control_permission,
    input  wire logic                   pin_func_sel,
    input  wire logic [3:0]             pin_enable,
    input  wire logic [3:0]             pin_level,
    input  wire logic                   high_field,
    input  wire logic                   sel_valid,
    input  wire logic [6:0]             sel_first_page,
    input  wire logic [6:0]             sel_last_page,
    output logic                        sel_reject,
    output logic                        tag_killed,
    output logic                        lock_page_active,
    output logic                        trim_locked,
    output logic                        battery_assist,
    output logic                        monitor_enable,
    output logic [31:0]                 seconds
);

    //------------------------------------------------------------------
    // Helpers
    //------------------------------------------------------------------
    function automatic logic [4:0] tcnt_inc(input logic [4:0] c);
        tcnt_inc = (c == tsw_pkg::TCNT_MAX) ? c : c + 5'h01;
    endfunction

    function automatic logic is_word(input tsw_pkg::tsw_word_req_t r,
                                     input logic [4:0] idx);
        is_word = r.valid && r.write && (r.idx == idx);
    endfunction

    //------------------------------------------------------------------
    // Pin synchronisers
    //------------------------------------------------------------------
    logic [4:0] pin_s1_reg;
    logic [4:0] pin_s2_reg;
    logic [4:0] pin_s3_reg;
    logic [4:0] pin_reg;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pin_s1_reg <= 5'h00;
            pin_s2_reg <= 5'h00;
            pin_s3_reg <= 5'h00;
        end else begin
            pin_s1_reg <= {high_field, pin_level};
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pin_reg <= 5'h00;
        end else begin
            for (int i = 0; i < 5; i++) begin
                if (pin_s2_reg[i] == pin_s3_reg[i]) begin
                    pin_reg[i] <= pin_s3_reg[i];
                end
            end
        end
    end

    logic [3:0] pin_shown;
    assign pin_shown = pin_func_sel ? 4'h0 : (pin_reg[3:0] & pin_enable);

    //------------------------------------------------------------------
    // Lock words
    //------------------------------------------------------------------
    logic [15:0] lock_reg [4];

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < 4; i++) begin
                lock_reg[i] <= tsw_pkg::LOCK_RST;
            end
        end else begin
            if (rf_req.valid && rf_req.write && rf_req.idx <= tsw_pkg::W_LOCK4) begin
                lock_reg[rf_req.idx[1:0]] <= rf_req.data;
            end else if (permalock_valid) begin
                if (!(&permalock_blk[5:4])) begin
                    lock_reg[permalock_blk[5:4]][4'hf - permalock_blk[3:0]] <= 1'b1;
                end else if (permalock_blk inside {[tsw_pkg::BLK_W4LO:tsw_pkg::BLK_TRIM]}) begin
                    // Blocks 59..61 then trim at 62 run down from bit four
                    lock_reg[3][3'(tsw_pkg::BLK_W4BIT
                        - (permalock_blk - tsw_pkg::BLK_W4LO))] <= 1'b1;
                end
            end
        end
    end

    assign tag_killed       = lock_reg[3][tsw_pkg::LK_KILL];
    assign trim_locked      = lock_reg[3][tsw_pkg::LK_TRIM];
    assign lock_page_active = lock_reg[3][tsw_pkg::LK_ACTIVE];

    //------------------------------------------------------------------
    // Battery assist word
    //------------------------------------------------------------------
    logic assist_reg;
    logic assist_rise;
    logic assist_ok;

    assign assist_ok = assist_control_permission && !spi_slave_mode && field_ok;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            assist_reg <= 1'b0;
        end else if (is_word(rf_req, tsw_pkg::W_ASSIST) && assist_ok) begin
            assist_reg <= rf_req.data[tsw_pkg::ASSIST_BIT];
        end
    end

    assign assist_rise = is_word(rf_req, tsw_pkg::W_ASSIST) && assist_ok
                         && !assist_reg && rf_req.data[tsw_pkg::ASSIST_BIT];
    assign battery_assist = assist_reg;

    //------------------------------------------------------------------
    // Alarms, temperature and monitoring counters
    //------------------------------------------------------------------
    logic       low_batt_reg;
    logic       aux_reg;
    logic       over_reg;
    logic       under_reg;
    logic [8:0] temp_reg;
    logic [5:0] abort_cnt_reg;
    logic [4:0] under_cnt_reg;
    logic [4:0] over_cnt_reg;
    logic       any_alarm;
    logic       is_under;
    logic       is_over;

    assign any_alarm = aux_reg || under_reg || over_reg;
    assign monitor_enable = assist_reg && interval_nonzero
                            && (!stamp_required || seconds != 32'h0);
    assign is_under = $signed(mon_sample.temp) < $signed(under_threshold);
    assign is_over  = $signed(mon_sample.temp) > $signed(over_threshold);

    // On-demand request: upper sensor word write or fetch command
    assign ondemand_go       = is_word(rf_req, tsw_pkg::W_SENS_HI)
                               || sensor_fetch_command;
    assign ondemand_tamper   = tamper_enable;
    assign ondemand_low_batt = assist_reg;
    assign ondemand_temp     = !(assist_reg ? low_batt_reg : !field_ok);

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            low_batt_reg <= 1'b0;
            aux_reg      <= 1'b0;
        end else begin
            if (alarm_reset_command) begin
                low_batt_reg <= 1'b0;
                aux_reg      <= 1'b0;
            end
            if (ondemand_result.valid && ondemand_low_batt) begin
                low_batt_reg <= ondemand_result.low_batt;
            end
            if (aux_event || (ondemand_result.valid && ondemand_tamper
                              && ondemand_result.tamper)) begin
                aux_reg <= 1'b1;
            end
        end
    end

    // One edge updates temperature, counters and alarms together
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            temp_reg      <= 9'h000;
            abort_cnt_reg <= 6'h00;
            under_cnt_reg <= 5'h00;
            over_cnt_reg  <= 5'h00;
            under_reg     <= 1'b0;
            over_reg      <= 1'b0;
        end else if (alarm_reset_command) begin
            abort_cnt_reg <= 6'h00;
            under_cnt_reg <= 5'h00;
            over_cnt_reg  <= 5'h00;
            under_reg     <= 1'b0;
            over_reg      <= 1'b0;
        end else if (mon_sample.valid && monitor_enable) begin
            if (mon_sample.aborted) begin
                temp_reg <= tsw_pkg::TEMP_ABORT;
                if (!under_reg && !over_reg && abort_cnt_reg != tsw_pkg::ABORT_MAX) begin
                    abort_cnt_reg <= abort_cnt_reg + 6'h01;
                end
            end else begin
                temp_reg <= mon_sample.temp;
                if (!under_reg) begin
                    if (!is_under) begin
                        under_cnt_reg <= 5'h00;
                    end else if (tcnt_inc(under_cnt_reg) == alarm_samples) begin
                        under_reg     <= 1'b1;
                        under_cnt_reg <= 5'h00;
                    end else begin
                        under_cnt_reg <= tcnt_inc(under_cnt_reg);
                    end
                end else if (is_under) begin
                    under_cnt_reg <= tcnt_inc(under_cnt_reg);
                end
                if (!over_reg) begin
                    if (!is_over) begin
                        over_cnt_reg <= 5'h00;
                    end else if (tcnt_inc(over_cnt_reg) == alarm_samples) begin
                        over_reg     <= 1'b1;
                        over_cnt_reg <= 5'h00;
                    end else begin
                        over_cnt_reg <= tcnt_inc(over_cnt_reg);
                    end
                end else if (is_over) begin
                    over_cnt_reg <= tcnt_inc(over_cnt_reg);
                end
            end
        end else if (ondemand_result.valid && ondemand_result.temp_valid) begin
            temp_reg <= ondemand_result.temp;
        end
    end

    //------------------------------------------------------------------
    // Seconds counter
    //------------------------------------------------------------------
    logic [31:0] sec_reg;
    logic [31:0] sec_load;
    logic        sec_load_en;
    logic [31:0] tick_reg;
    logic        tick;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            tick_reg <= 32'h0;
        end else if (!assist_reg || tick) begin
            tick_reg <= 32'h0;
        end else begin
            tick_reg <= tick_reg + 32'h1;
        end
    end

    assign tick = (tick_reg == 32'(SEC_CYCLES - 1));

    always_comb begin
        sec_load    = time_broadcast_value;
        sec_load_en = time_broadcast_command;
        if (is_word(rf_req, tsw_pkg::W_CLK_HI)) begin
            sec_load    = {rf_req.data, sec_reg[15:0]};
            sec_load_en = 1'b1;
        end else if (is_word(rf_req, tsw_pkg::W_CLK_LO)) begin
            sec_load    = {sec_reg[31:16], rf_req.data};
            sec_load_en = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sec_reg <= 32'h0;
        end else if (assist_rise || alarm_reset_command || sensor_page_written) begin
            sec_reg <= 32'h0;
        end else if (sec_load_en && !any_alarm && sec_load[31:24] != 8'h00) begin
            sec_reg <= sec_load;
        end else if (tick && assist_reg && sec_reg[31:24] != 8'h00 && !any_alarm) begin
            sec_reg <= sec_reg + 32'h1;
        end
    end

    assign seconds = sec_reg;

    //------------------------------------------------------------------
    // Scratch words
    //------------------------------------------------------------------
    logic [15:0] scr_mem [8];
    logic [3:0]  scr_nib_reg;
    logic        rf_scr_wr;
    logic        rf_scr_blocked;

    assign rf_scr_blocked = rf_req.idx[2] ? scr_page1_is_id : scr_page0_is_id;
    assign rf_scr_wr = rf_req.valid && rf_req.write && rf_req.idx >= tsw_pkg::W_SCR0
                       && rf_req.idx <= tsw_pkg::W_SCR7 && !rf_scr_blocked;

    always_ff @(posedge mclk) begin
        if (spi_wr) begin
            scr_mem[spi_idx] <= spi_wdata;
        end else if (rf_scr_wr) begin
            scr_mem[rf_req.idx[2:0]] <= rf_req.data;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            scr_nib_reg <= 4'h0;
        end else if (spi_wr && spi_idx == 3'h0) begin
            scr_nib_reg <= spi_wdata[15:tsw_pkg::SCR_NIB_LO];
        end else if (rf_scr_wr && rf_req.idx[2:0] == 3'h0) begin
            scr_nib_reg <= rf_req.data[15:tsw_pkg::SCR_NIB_LO];
        end else if (sleep_ready_boot && !scr_page0_is_id) begin
            scr_nib_reg <= 4'h0;
        end
    end

    function automatic logic [15:0] scr_word(input logic [2:0] i);
        scr_word = (i == 3'h0)
            ? {scr_nib_reg, scr_mem[0][tsw_pkg::SCR_NIB_LO-1:0]} : scr_mem[i];
    endfunction

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            spi_rdata <= 16'h0000;
        end else begin
            spi_rdata <= scr_word(spi_idx);
        end
    end

    //------------------------------------------------------------------
    // Reader read path and answers
    //------------------------------------------------------------------
    logic [15:0] rd_word;
    logic        wr_refused;

    always_comb begin
        rd_word    = 16'h0000;
        wr_refused = 1'b0;
        if (rf_req.idx <= tsw_pkg::W_LOCK4) begin
            rd_word = lock_reg[rf_req.idx[1:0]];
        end else if (rf_req.idx == tsw_pkg::W_SENS_HI) begin
            rd_word = {low_batt_reg, aux_reg, over_reg, under_reg, pin_shown[3],
                       monitor_enable, 1'b0, temp_reg};
        end else if (rf_req.idx == tsw_pkg::W_SENS_LO) begin
            rd_word    = {abort_cnt_reg, under_cnt_reg, over_cnt_reg};
            wr_refused = 1'b1;
        end else if (rf_req.idx == tsw_pkg::W_CLK_HI) begin
            rd_word    = sec_reg[31:16];
            wr_refused = !sec_load_en || any_alarm || sec_load[31:24] == 8'h00;
        end else if (rf_req.idx == tsw_pkg::W_CLK_LO) begin
            rd_word    = sec_reg[15:0];
            wr_refused = !sec_load_en || any_alarm || sec_load[31:24] == 8'h00;
        end else if (rf_req.idx <= tsw_pkg::W_SCR7) begin
            rd_word    = scr_word(rf_req.idx[2:0]);
            wr_refused = rf_scr_blocked;
        end else if (rf_req.idx == tsw_pkg::W_PINS) begin
            rd_word = {pin_reg[4], 11'h000, pin_shown};
            rd_word[tsw_pkg::PIN_HIGHF] = pin_reg[4];
        end else if (rf_req.idx == tsw_pkg::W_ASSIST) begin
            rd_word    = {15'h0000, assist_reg};
            wr_refused = !assist_ok;
        end else begin
            wr_refused = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rf_done    <= 1'b0;
            rf_refused <= 1'b0;
            rf_rdata   <= 16'h0000;
        end else begin
            rf_done    <= rf_req.valid;
            rf_refused <= rf_req.valid && rf_req.write && wr_refused;
            if (rf_req.valid && !rf_req.write) begin
                rf_rdata <= rd_word;
            end
        end
    end

    //------------------------------------------------------------------
    // Select restriction
    //------------------------------------------------------------------
    assign sel_reject = sel_valid && sel_first_page <= tsw_pkg::SEL_PAGE
                        && sel_last_page >= tsw_pkg::SEL_PAGE;

endmodule

`default_nettype wire

/* File: rtl/tsw_pkg.sv */
/*
 * Constants, word indices, field positions and carrier structs for the
 * tag system-word block. Assumes a single 100 MHz clock domain.
 */
package tsw_pkg;

    // Clock and seconds tick
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned SEC_TIME_NS   = 1000000000;
    localparam int unsigned SEC_CYCLES    = SEC_TIME_NS / CLK_PERIOD_NS;

    // Word indices on the reader word port
    localparam logic [4:0] W_LOCK1   = 5'h00;
    localparam logic [4:0] W_LOCK2   = 5'h01;
    localparam logic [4:0] W_LOCK3   = 5'h02;
    localparam logic [4:0] W_LOCK4   = 5'h03;
    localparam logic [4:0] W_SENS_HI = 5'h04;
    localparam logic [4:0] W_SENS_LO = 5'h05;
    localparam logic [4:0] W_CLK_HI  = 5'h06;
    localparam logic [4:0] W_CLK_LO  = 5'h07;
    localparam logic [4:0] W_SCR0    = 5'h08;
    localparam logic [4:0] W_SCR7    = 5'h0f;
    localparam logic [4:0] W_PINS    = 5'h10;
    localparam logic [4:0] W_ASSIST  = 5'h11;

    // Lock word 4 fields
    localparam int unsigned LK_KILL   = 15;
    localparam int unsigned LK_TRIM   = 1;
    localparam int unsigned LK_ACTIVE = 0;
    localparam logic [5:0]  BLK_TRIM  = 6'h3e;
    localparam logic [5:0]  BLK_W4LO  = 6'h3b;
    localparam logic [5:0]  BLK_W4BIT = 6'h04;
    localparam logic [15:0] LOCK_RST  = 16'h0000;

    // Sensor word fields
    localparam int unsigned SN_LOWBAT = 15;
    localparam int unsigned SN_AUX    = 14;
    localparam int unsigned SN_OVER   = 13;
    localparam int unsigned SN_UNDER  = 12;
    localparam int unsigned SN_P3     = 11;
    localparam int unsigned SN_MONEN  = 10;
    localparam logic [8:0]  TEMP_ABORT = 9'h100;
    localparam logic [5:0]  ABORT_MAX  = 6'h3f;
    localparam logic [4:0]  TCNT_MAX   = 5'h1f;

    // Scratch, pin word, assist word, select restriction
    localparam int unsigned SCR_NIB_LO = 12;
    localparam int unsigned PIN_HIGHF  = 15;
    localparam int unsigned ASSIST_BIT = 0;
    localparam logic [6:0]  SEL_PAGE   = 7'h40;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [4:0]  idx;
        logic [15:0] data;
    } tsw_word_req_t;

    typedef struct packed {
        logic        valid;
        logic        aborted;
        logic [8:0]  temp;
    } tsw_meas_t;

    typedef struct packed {
        logic        valid;
        logic        tamper;
        logic        low_batt;
        logic        temp_valid;
        logic [8:0]  temp;
    } tsw_ondemand_t;

endpackage

/* File: sim/tsw_props_properties.sv */
/* Port checker for the tag system-word block.
   Assumes one mclk domain and the active-low reset_n. */
`timescale 1ns/1ns
`default_nettype none
module tsw_props (
    input wire logic                   mclk,
    input wire logic                   reset_n,
    input wire tsw_pkg::tsw_word_req_t rf_req,
    input wire logic                   rf_done,
    input wire logic                   rf_refused,
    input wire logic                   permalock_valid,
    input wire logic [5:0]             permalock_blk,
    input wire logic                   trim_locked,
    input wire logic                   tag_killed,
    input wire logic                   ondemand_go,
    input wire logic                   battery_assist,
    input wire logic                   assist_control_permission,
    input wire logic                   alarm_reset_command,
    input wire logic [31:0]            seconds,
    input wire logic                   sel_valid,
    input wire logic [6:0]             sel_first_page,
    input wire logic [6:0]             sel_last_page,
    input wire logic                   sel_reject
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    wire logic wr = rf_req.valid && rf_req.write;
    chk_done_cause: assert property (rf_done |-> $past(rf_req.valid))
        else $error("done without request");
    chk_kill_flag: assert property (wr && rf_req.idx == 5'h03
        |=> tag_killed == $past(rf_req.data[15])) else $error("kill flag wrong");
    chk_trim_block: assert property (permalock_valid && permalock_blk == 6'h3e
        && !wr |=> trim_locked) else $error("trim lock not set");
    chk_sensor_ro: assert property (wr && rf_req.idx == 5'h05 |=> rf_refused)
        else $error("sensor write accepted");
    chk_sample_start: assert property (wr && rf_req.idx == 5'h04 |-> ondemand_go)
        else $error("no sample started");
    chk_alarm_clear: assert property (alarm_reset_command |=> seconds == 32'h0)
        else $error("seconds not cleared");
    chk_assist_perm: assert property (wr && rf_req.idx == 5'h11
        && !assist_control_permission |=> $stable(battery_assist))
        else $error("assist changed");
    chk_select_page: assert property (sel_reject == (sel_valid
        && sel_first_page <= 7'h40 && sel_last_page >= 7'h40)) else $error("select");
    cover property (rf_refused);
    cover property (trim_locked);
    cover property (sel_reject);
endmodule
bind tsw_system_words tsw_props u_chk (.*);
`default_nettype wire

/* File: sim/tsw_sampler.sv */
/* Sensor sampler model answering on-demand requests.
   Assumes single-cycle request pulses on mclk. */
`timescale 1ns/1ns
`default_nettype none
module tsw_sampler (
    input  wire logic                   mclk,
    input  wire logic                   ondemand_go,
    input  wire logic                   ondemand_tamper,
    input  wire logic                   ondemand_temp,
    output var  tsw_pkg::tsw_ondemand_t ondemand_result
);
    initial ondemand_result = '0;
    // Fixed reading, battery always fine
    always @(posedge mclk) begin
        ondemand_result <= {ondemand_go, ondemand_go & ondemand_tamper, 1'b0,
                            ondemand_go & ondemand_temp, 9'h028};
    end
endmodule
`default_nettype wire

/* File: sim/tsw_system_words_bench.sv */
/* Self-checking bench for the tag system-word block.
   Assumes the sampler model on the on-demand port. */
`timescale 1ns/1ns
`default_nettype none
module tsw_system_words_bench;
    tsw_pkg::tsw_word_req_t rf_req;
    tsw_pkg::tsw_ondemand_t ondemand_result;
    tsw_pkg::tsw_meas_t     mon_sample;
    logic                   mclk, reset_n, rf_done, rf_refused, spi_wr, permalock_valid;
    logic                   sensor_fetch_command, ondemand_go, ondemand_tamper, ondemand_low_batt;
    logic                   ondemand_temp, interval_nonzero, stamp_required, tamper_enable;
    logic                   aux_event, alarm_reset_command, time_broadcast_command, field_ok;
    logic                   sensor_page_written, sleep_ready_boot, scr_page0_is_id, high_field;
    logic                   scr_page1_is_id, spi_slave_mode, assist_control_permission;
    logic                   pin_func_sel, sel_valid, sel_reject, tag_killed, lock_page_active;
    logic                   trim_locked, battery_assist, monitor_enable;
    logic [2:0]             spi_idx;
    logic [3:0]             pin_enable, pin_level;
    logic [4:0]             alarm_samples;
    logic [5:0]             permalock_blk;
    logic [6:0]             sel_first_page, sel_last_page;
    logic [8:0]             under_threshold, over_threshold;
    logic [15:0]            rf_rdata, spi_wdata, spi_rdata;
    logic [17:0]            e, exp_q[$];
    logic [31:0]            time_broadcast_value, seconds, seed, r;
    int                     mismatches, checks_done;
    tsw_system_words #(.SEC_CYCLES(20)) u_dut (.*);
    tsw_sampler u_smp (.*);
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic cmp(input logic [15:0] got, input logic [15:0] want);
        checks_done++;
        if (got !== want) begin
            mismatches++;
            $display("mismatch at %0t: got %h want %h", $time, got, want);
        end
    endtask
    task automatic acc(input logic w, input logic [4:0] i, input logic [15:0] d,
                       input logic rf, input logic [15:0] x);
        @(posedge mclk) rf_req <= {1'b1, w, i, d};
        exp_q.push_back({~w, rf, x});
        @(posedge mclk) rf_req.valid <= 1'b0;
    endtask
    task automatic smp(input logic [9:0] s);
        @(posedge mclk) mon_sample <= {1'b1, s};
        @(posedge mclk) mon_sample.valid <= 1'b0;
    endtask
    task automatic end_of_test();
        if (mismatches == 0 && checks_done > 0 && exp_q.size() == 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    always @(negedge mclk) begin
        if (rf_done === 1'b1) begin
            e = exp_q.pop_front();
            cmp(16'(rf_refused), 16'(e[16]));
            if (e[17]) cmp(rf_rdata, e[15:0]);
        end
    end
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        #100000;
        mismatches++;
        end_of_test();
    end
    initial begin
        {rf_req, mon_sample, spi_wr, spi_idx, spi_wdata, permalock_valid, reset_n} = '0;
        {sensor_fetch_command, stamp_required, tamper_enable, aux_event, sel_valid} = '0;
        {alarm_reset_command, time_broadcast_command, time_broadcast_value} = '0;
        {sensor_page_written, sleep_ready_boot, scr_page0_is_id, scr_page1_is_id} = '0;
        {spi_slave_mode, pin_enable, pin_level, high_field, under_threshold} = '0;
        {sel_first_page, sel_last_page} = '0;
        {field_ok, assist_control_permission, pin_func_sel, interval_nonzero} = 4'hf;
        {over_threshold, alarm_samples, permalock_blk, seed} = {9'h0ff, 5'h02, 6'h3e, 32'h46};
        repeat (6) @(posedge mclk);
        reset_n <= 1'b1;
        r = rnd();
        acc(1'b1, 5'h03, r[15:0], 1'b0, 16'h0);
        @(posedge mclk) permalock_valid <= 1'b1;
        @(posedge mclk) permalock_valid <= 1'b0;
        acc(1'b0, 5'h03, 16'h0, 1'b0, r[15:0] | 16'h0002);
        acc(1'b1, 5'h05, r[15:0], 1'b1, 16'h0);
        acc(1'b1, 5'h14, 16'h0, 1'b1, 16'h0);
        r = rnd();
        acc(1'b1, 5'h09, r[15:0], 1'b0, 16'h0);
        @(posedge mclk) spi_wr <= 1'b1;
        spi_wdata <= 16'hffff;
        @(posedge mclk) spi_wr <= 1'b0;
        @(posedge mclk) sleep_ready_boot <= 1'b1;
        @(posedge mclk) sleep_ready_boot <= 1'b0;
        acc(1'b0, 5'h08, 16'h0, 1'b0, 16'h0fff);
        @(negedge mclk) cmp(spi_rdata, 16'h0fff);
        acc(1'b0, 5'h09, 16'h0, 1'b0, r[15:0]);
        acc(1'b1, 5'h11, 16'h0001, 1'b0, 16'h0);
        assist_control_permission <= 1'b0;
        acc(1'b1, 5'h11, 16'h0, 1'b1, 16'h0);
        acc(1'b0, 5'h11, 16'h0, 1'b0, 16'h0001);
        @(posedge mclk) time_broadcast_command <= 1'b1;
        time_broadcast_value <= 32'h3400_0000;
        @(posedge mclk) time_broadcast_command <= 1'b0;
        acc(1'b0, 5'h06, 16'h0, 1'b0, 16'h3400);
        acc(1'b1, 5'h06, 16'h0, 1'b1, 16'h0);
        @(posedge mclk) sensor_page_written <= 1'b1;
        @(posedge mclk) sensor_page_written <= 1'b0;
        acc(1'b0, 5'h06, 16'h0, 1'b0, 16'h0);
        smp(10'h200);
        repeat (3) smp(10'h1f0);
        acc(1'b0, 5'h05, 16'h0, 1'b0, 16'h0420);
        acc(1'b0, 5'h04, 16'h0, 1'b0, 16'h15f0);
        @(posedge mclk) alarm_reset_command <= 1'b1;
        @(posedge mclk) alarm_reset_command <= 1'b0;
        acc(1'b0, 5'h05, 16'h0, 1'b0, 16'h0);
        acc(1'b1, 5'h04, 16'h1234, 1'b0, 16'h0);
        @(posedge mclk) sensor_fetch_command <= 1'b1;
        tamper_enable <= 1'b1;
        @(posedge mclk) sensor_fetch_command <= 1'b0;
        repeat (3) @(posedge mclk);
        acc(1'b0, 5'h04, 16'h0, 1'b0, 16'h4428);
        repeat (16) begin
            @(posedge mclk) r = rnd();
            {sel_valid, sel_first_page, sel_last_page} <= r[14:0];
        end
        {pin_func_sel, pin_enable, pin_level, high_field} <= 10'h0f3;
        repeat (5) @(posedge mclk);
        acc(1'b0, 5'h10, 16'h0, 1'b0, 16'h8001);
        repeat (3) @(posedge mclk);
        end_of_test();
    end
endmodule
`default_nettype wire
